/* core/branch_sub_xor_pkg.sv */
// Constants, types and decode functions shared by the instruction subset core
package branch_sub_xor_pkg;

   // **********************************************************************
   // Opcodes and opcode masks
   // **********************************************************************
   localparam logic [7:0] OP_BRANCH    = 8'h80;
   localparam logic [7:0] OP_SUB_IMM   = 8'h94;
   localparam logic [7:0] OP_SUB_DIR   = 8'h95;
   localparam logic [7:0] OP_SUB_IND   = 8'h96;
   localparam logic [7:0] OP_SUB_REG   = 8'h98;
   localparam logic [7:0] OP_SWAP      = 8'hC4;
   localparam logic [7:0] OP_XCH_DIR   = 8'hC5;
   localparam logic [7:0] OP_XCH_IND   = 8'hC6;
   localparam logic [7:0] OP_XCH_REG   = 8'hC8;
   localparam logic [7:0] OP_TRADE_LOW_NIBBLE_IND  = 8'hD6;
   localparam logic [7:0] OP_XRL_DIR_A = 8'h62;
   localparam logic [7:0] OP_XRL_DIR_I = 8'h63;
   localparam logic [7:0] OP_XRL_IMM   = 8'h64;
   localparam logic [7:0] OP_XRL_DIR   = 8'h65;
   localparam logic [7:0] OP_XRL_IND   = 8'h66;
   localparam logic [7:0] OP_XRL_REG   = 8'h68;
   localparam logic [7:0] MASK_IND     = 8'hFE;
   localparam logic [7:0] MASK_REG     = 8'hF8;

   // **********************************************************************
   // Special function addresses, reset values and instruction length codes
   // **********************************************************************
   localparam logic [7:0]  SFR_BASE  = 8'h80;
   localparam logic [7:0]  ADDR_ACC  = 8'hE0;
   localparam logic [7:0]  ADDR_PORT = 8'h90;
   localparam logic [15:0] PC_RST    = 16'h0000;
   localparam logic [7:0]  ACC_RST   = 8'h00;
   localparam logic [7:0]  PORT_RST  = 8'hFF;
   localparam logic [1:0]  LEN_ONE   = 2'h1;
   localparam logic [1:0]  LEN_TWO   = 2'h2;
   localparam logic [1:0]  LEN_THREE = 2'h3;

   // **********************************************************************
   // Types
   // **********************************************************************
   typedef enum logic [2:0] {S_FETCH, S_B2, S_B3, S_ADDR, S_PTR, S_EXEC} state_t;
   typedef enum logic [2:0] {K_NONE, K_BRANCH, K_SUB, K_SWAP, K_XCH, K_TRADE_LOW_NIBBLE,
                             K_XRLA, K_XRLD} kind_t;
   typedef enum logic [2:0] {M_NONE, M_IMM, M_DIR, M_IND, M_REG} mode_t;

   // Instruction family of an opcode
   function automatic kind_t kind_of(input logic [7:0] op);
      if (op == OP_BRANCH)
         return K_BRANCH;
      if (op == OP_SUB_IMM || op == OP_SUB_DIR || (op & MASK_IND) == OP_SUB_IND ||
          (op & MASK_REG) == OP_SUB_REG)
         return K_SUB;
      if (op == OP_SWAP)
         return K_SWAP;
      if (op == OP_XCH_DIR || (op & MASK_IND) == OP_XCH_IND ||
          (op & MASK_REG) == OP_XCH_REG)
         return K_XCH;
      if ((op & MASK_IND) == OP_TRADE_LOW_NIBBLE_IND)
         return K_TRADE_LOW_NIBBLE;
      if (op == OP_XRL_IMM || op == OP_XRL_DIR || (op & MASK_IND) == OP_XRL_IND ||
          (op & MASK_REG) == OP_XRL_REG)
         return K_XRLA;
      if (op == OP_XRL_DIR_A || op == OP_XRL_DIR_I)
         return K_XRLD;
      return K_NONE;
   endfunction

   // Operand addressing mode; the accumulator forms share the low-nibble layout
   function automatic mode_t mode_of(input logic [7:0] op);
      kind_t k;
      k = kind_of(op);
      if (k == K_TRADE_LOW_NIBBLE)
         return M_IND;
      if (k == K_XRLD)
         return M_DIR;
      if (k == K_SUB || k == K_XCH || k == K_XRLA) begin
         if (op[3])
            return M_REG;
         if (op[3:1] == 3'h3)
            return M_IND;
         if (op[0])
            return M_DIR;
         return M_IMM;
      end
      return M_NONE;
   endfunction

   // Byte length of an instruction
   function automatic logic [1:0] len_of(input logic [7:0] op);
      mode_t m;
      m = mode_of(op);
      if (op == OP_XRL_DIR_I)
         return LEN_THREE;
      if (op == OP_BRANCH || m == M_DIR || m == M_IMM)
         return LEN_TWO;
      return LEN_ONE;
   endfunction

   // Machine cycles of an instruction
   function automatic logic [1:0] cyc_of(input logic [7:0] op);
      if (op == OP_BRANCH || op == OP_XRL_DIR_I)
         return LEN_TWO;
      return LEN_ONE;
   endfunction

endpackage

/* core/data_ram.sv */
// Internal data memory, 256 bytes, registered read data
`timescale 1ns/10ps
module data_ram
   import branch_sub_xor_pkg::*;
(
   // Clock
   input  wire logic       clock,
   // Write port
   input  wire logic       we,
   input  wire logic [7:0] waddr,
   input  wire logic [7:0] wdata,
   // Read port
   input  wire logic [7:0] raddr,
   output logic      [7:0] rdata_r
);

   logic [7:0] mem [256];

   // Read before write on a shared address
   always_ff @(posedge clock) begin
      if (we)
         mem[waddr] <= wdata;
      rdata_r <= mem[raddr];
   end

endmodule

/* core/borrow_sub_unit.sv */
// Eight-bit subtract with borrow and its three flags
`timescale 1ns/10ps
module borrow_sub_unit
   import branch_sub_xor_pkg::*;
(
   // Operands
   input  wire logic [7:0] minuend,
   input  wire logic [7:0] subtrahend,
   input  wire logic       borrow_in,
   // Results
   output logic      [7:0] diff,
   output logic            borrow7,
   output logic            borrow3,
   output logic            wrap
);

   logic [4:0] low_d;
   logic [7:0] mid_d;
   logic [8:0] full_d;

   // Borrow out of bits 3, 6 and 7 from widened partial differences
   always_comb begin
      low_d   = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
      mid_d   = {1'b0, minuend[6:0]} - {1'b0, subtrahend[6:0]} - {7'h00, borrow_in};
      full_d  = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
      diff    = full_d[7:0];
      borrow7 = full_d[8];
      borrow3 = low_d[4];
      wrap    = mid_d[7] ^ full_d[8];
   end

endmodule

/* core/branch_sub_xor_core.sv */
// Decode and execute of relative branch, borrow subtract, swap, trades and xor
`timescale 1ns/10ps
module branch_sub_xor_core
   import branch_sub_xor_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        srst,
   // Program memory
   output logic      [15:0] pm_addr,
   input  wire logic [7:0]  pm_data,
   // Core context
   input  wire logic [1:0]  bank_sel,
   input  wire logic [7:0]  port_pins,
   // Architectural state
   output logic      [7:0]  acc,
   output logic             carry_flag,
   output logic             half_borrow_flag,
   output logic             signed_wrap_flag,
   output logic      [7:0]  port_latch,
   // Completion
   output logic             instr_done,
   output logic      [1:0]  instr_cycles
);

   // **********************************************************************
   // State
   // **********************************************************************
   typedef struct packed {
      state_t      state;
      logic [15:0] pc;
      logic [7:0]  op;
      logic [7:0]  b2;
      logic [7:0]  b3;
      logic [7:0]  opaddr;
      logic [7:0]  acc;
      logic        cy;
      logic        hb;
      logic        sw;
      logic [7:0]  latch;
      logic        done;
      logic [1:0]  cyc;
   } core_state_t;

   core_state_t st_r;
   core_state_t st_nxt;

   kind_t       kind_c;
   mode_t       mode_c;
   logic        is_sfr;
   logic [7:0]  sfr_val;
   logic [7:0]  opval;
   logic [7:0]  xor_src;
   logic [15:0] branch_tgt;
   logic        dest_we;
   logic [7:0]  dest_data;
   logic        ram_we;
   logic [7:0]  ram_waddr;
   logic [7:0]  ram_wdata;
   logic [7:0]  ram_raddr;
   logic [7:0]  ram_rdata;
   logic [7:0]  sub_diff;
   logic        sub_b7;
   logic        sub_b3;
   logic        sub_wrap;

   // Bank register address inside the internal RAM
   function automatic logic [7:0] reg_addr(input logic [1:0] bank, input logic [2:0] r);
      return {3'h0, bank, r};
   endfunction

   // **********************************************************************
   // Operand fetch
   // **********************************************************************

   // Decoded fields of the held opcode
   assign kind_c = kind_of(st_r.op);
   assign mode_c = mode_of(st_r.op);
   assign is_sfr = (mode_c == M_DIR) && (st_r.opaddr >= SFR_BASE);

   // latch not pins
   // Read-modify-write of the port must not pick up loaded pin levels
   always_comb begin
      if (st_r.opaddr == ADDR_ACC)
         sfr_val = st_r.acc;
      else if (st_r.opaddr == ADDR_PORT)
         sfr_val = (kind_c == K_XRLD) ? st_r.latch : port_pins;
      else
         sfr_val = 8'h00;
   end

   always_comb begin
      if (mode_c == M_IMM)
         opval = st_r.b2;
      else if (is_sfr)
         opval = sfr_val;
      else
         opval = ram_rdata;
   end

   // Second xor operand for the direct destination forms
   assign xor_src = (st_r.op == OP_XRL_DIR_I) ? st_r.b3 : st_r.acc;

   assign branch_tgt = st_r.pc + {{8{st_r.b2[7]}}, st_r.b2};

   // **********************************************************************
   // Submodules
   // **********************************************************************
   borrow_sub_unit u_sub (
      .minuend    (st_r.acc),
      .subtrahend (opval),
      .borrow_in  (st_r.cy),
      .diff       (sub_diff),
      .borrow7    (sub_b7),
      .borrow3    (sub_b3),
      .wrap       (sub_wrap)
   );

   data_ram u_ram (
      .clock   (clock),
      .we      (ram_we),
      .waddr   (ram_waddr),
      .wdata   (ram_wdata),
      .raddr   (ram_raddr),
      .rdata_r (ram_rdata)
   );

   // **********************************************************************
   // Sequencer
   // **********************************************************************

   // Next state; RAM reads are issued one state ahead of their use
   always_comb begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      ram_raddr   = 8'h00;
      ram_we      = 1'b0;
      ram_waddr   = st_r.opaddr;
      ram_wdata   = 8'h00;
      dest_we     = 1'b0;
      dest_data   = 8'h00;
      case (st_r.state)
         S_FETCH: begin
            st_nxt.op  = pm_data;
            st_nxt.pc  = st_r.pc + 16'h0001;
            st_nxt.cyc = cyc_of(pm_data);
            st_nxt.state = (len_of(pm_data) != LEN_ONE) ? S_B2 : S_ADDR;
         end
         S_B2: begin
            st_nxt.b2    = pm_data;
            st_nxt.pc    = st_r.pc + 16'h0001;
            st_nxt.state = (len_of(st_r.op) == LEN_THREE) ? S_B3 : S_ADDR;
         end
         S_B3: begin
            st_nxt.b3    = pm_data;
            st_nxt.pc    = st_r.pc + 16'h0001;
            st_nxt.state = S_ADDR;
         end
         S_ADDR: begin
            case (mode_c)
               M_REG: begin
                  st_nxt.opaddr = reg_addr(bank_sel, st_r.op[2:0]);
                  ram_raddr     = reg_addr(bank_sel, st_r.op[2:0]);
                  st_nxt.state  = S_EXEC;
               end
               M_DIR: begin
                  st_nxt.opaddr = st_r.b2;
                  ram_raddr     = st_r.b2;
                  st_nxt.state  = S_EXEC;
               end
               M_IND: begin
                  // Pointer register first, then the byte it addresses
                  ram_raddr    = reg_addr(bank_sel, {2'h0, st_r.op[0]});
                  st_nxt.state = S_PTR;
               end
               default: begin
                  st_nxt.state = S_EXEC;
               end
            endcase
         end
         S_PTR: begin
            st_nxt.opaddr = ram_rdata;
            ram_raddr     = ram_rdata;
            st_nxt.state  = S_EXEC;
         end
         S_EXEC: begin
            st_nxt.done  = 1'b1;
            st_nxt.state = S_FETCH;
            case (kind_c)
               K_BRANCH: begin
                  st_nxt.pc = branch_tgt;
               end
               K_SUB: begin
                  st_nxt.acc = sub_diff;
                  st_nxt.cy  = sub_b7;
                  st_nxt.hb  = sub_b3;
                  st_nxt.sw  = sub_wrap;
               end
               K_SWAP: begin
                  st_nxt.acc = {st_r.acc[3:0], st_r.acc[7:4]};
               end
               K_XCH: begin
                  st_nxt.acc = opval;
                  dest_we    = 1'b1;
                  dest_data  = st_r.acc;
               end
               K_TRADE_LOW_NIBBLE: begin
                  st_nxt.acc = {st_r.acc[7:4], opval[3:0]};
                  dest_we    = 1'b1;
                  dest_data  = {opval[7:4], st_r.acc[3:0]};
               end
               K_XRLA: begin
                  st_nxt.acc = st_r.acc ^ opval;
               end
               K_XRLD: begin
                  dest_we   = 1'b1;
                  dest_data = opval ^ xor_src;
               end
               default: begin
                  st_nxt.done = 1'b1;
               end
            endcase
            // Destination write; accumulator and port live outside the RAM
            if (dest_we) begin
               if (is_sfr) begin
                  if (st_r.opaddr == ADDR_ACC)
                     st_nxt.acc = dest_data;
                  else if (st_r.opaddr == ADDR_PORT)
                     st_nxt.latch = dest_data;
               end else begin
                  ram_we    = 1'b1;
                  ram_wdata = dest_data;
               end
            end
         end
         default: begin
            st_nxt.state = S_FETCH;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock) begin
      if (srst) begin
         st_r       <= '0;
         st_r.state <= S_FETCH;
         st_r.pc    <= PC_RST;
         st_r.acc   <= ACC_RST;
         st_r.latch <= PORT_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign pm_addr          = st_r.pc;
   assign acc              = st_r.acc;
   assign carry_flag       = st_r.cy;
   assign half_borrow_flag = st_r.hb;
   assign signed_wrap_flag = st_r.sw;
   assign port_latch       = st_r.latch;
   assign instr_done       = st_r.done;
   assign instr_cycles     = st_r.cyc;

   // **********************************************************************
   // Assertions
   // **********************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   logic exec_c;
   assign exec_c = (st_r.state == S_EXEC);

   sequence two_byte_fetch;
      (st_r.state == S_B2) ##1 (st_r.state == S_ADDR);
   endsequence

   sequence three_byte_fetch;
      (st_r.state == S_B2) ##1 (st_r.state == S_B3) ##1 (st_r.state == S_ADDR);
   endsequence

   a_branch_fetch_len: assert property (
      (st_r.state == S_FETCH && pm_data == OP_BRANCH) |=> two_byte_fetch ##1 exec_c)
      else $error("branch did not fetch two bytes");

   a_branch_target: assert property (
      (exec_c && kind_c == K_BRANCH) |=> (st_r.pc == $past(st_r.pc) +
         {{8{$past(st_r.b2[7])}}, $past(st_r.b2)}))
      else $error("branch target wrong");

   a_sub_result: assert property (
      (exec_c && kind_c == K_SUB) |=>
         (st_r.acc == 8'($past(st_r.acc) - $past(opval) - {7'h00, $past(st_r.cy)})))
      else $error("subtract result wrong");

   a_sub_carry: assert property (
      (exec_c && kind_c == K_SUB) |=> (st_r.cy == ({1'b0, $past(st_r.acc)} <
         ({1'b0, $past(opval)} + {8'h00, $past(st_r.cy)}))))
      else $error("subtract carry wrong");

   a_sub_half: assert property (
      (exec_c && kind_c == K_SUB) |=> (st_r.hb == ({1'b0, $past(st_r.acc[3:0])} <
         ({1'b0, $past(opval[3:0])} + {4'h0, $past(st_r.cy)}))))
      else $error("half-borrow flag wrong");

   a_sub_wrap: assert property (
      (exec_c && kind_c == K_SUB) |=> (st_r.sw == (($past(st_r.acc[7]) !=
         $past(opval[7])) && (st_r.acc[7] != $past(st_r.acc[7])))))
      else $error("signed-wrap flag wrong");

   a_sub_imm_cycles: assert property (
      (st_r.state == S_FETCH && pm_data == OP_SUB_IMM) |=> (st_r.cyc == LEN_ONE)
         ##0 two_byte_fetch ##1 exec_c ##1 st_r.done)
      else $error("immediate subtract cycle count wrong");

   a_swap_nibbles: assert property (
      (exec_c && kind_c == K_SWAP) |=> (st_r.acc == {$past(st_r.acc[3:0]),
         $past(st_r.acc[7:4])}) && $stable({st_r.cy, st_r.hb, st_r.sw}))
      else $error("nibble rotate wrong");

   a_trade_byte: assert property (
      (exec_c && kind_c == K_XCH && !is_sfr) |-> ram_we && (ram_wdata == st_r.acc)
         ##1 (st_r.acc == $past(opval)))
      else $error("byte trade wrong");

   a_trade_nibble: assert property (
      (exec_c && kind_c == K_TRADE_LOW_NIBBLE) |-> (ram_wdata == {opval[7:4], st_r.acc[3:0]})
         ##1 (st_r.acc == {$past(st_r.acc[7:4]), $past(opval[3:0])}))
      else $error("low-nibble trade wrong");

   a_xor_flags: assert property (
      (exec_c && (kind_c == K_XRLA || kind_c == K_XRLD)) |=>
         $stable({st_r.cy, st_r.hb, st_r.sw}))
      else $error("xor changed a flag");

   a_xor_port_latch: assert property (
      (exec_c && kind_c == K_XRLD && st_r.opaddr == ADDR_PORT) |=>
         (st_r.latch == ($past(st_r.latch) ^ $past(xor_src))))
      else $error("port xor did not use the latch");

   a_xor_acc: assert property (
      (exec_c && kind_c == K_XRLA) |=> (st_r.acc == ($past(st_r.acc) ^ $past(opval))))
      else $error("xor into accumulator wrong");

   a_xor_imm_len: assert property (
      (st_r.state == S_FETCH && pm_data == OP_XRL_IMM) |=> (st_r.cyc == LEN_ONE)
         ##0 two_byte_fetch)
      else $error("xor immediate length wrong");

   a_xor_dir_len: assert property (
      (st_r.state == S_FETCH && pm_data == OP_XRL_DIR_A) |=> two_byte_fetch)
      else $error("xor direct length wrong");

   a_xor_dir_imm_len: assert property (
      (st_r.state == S_FETCH && pm_data == OP_XRL_DIR_I) |=> (st_r.cyc == LEN_TWO)
         ##0 three_byte_fetch)
      else $error("xor direct immediate length wrong");

endmodule

/* test/prog_mem_model.sv */
// Program memory model: one combinational byte read port
`timescale 1ns/10ps
module prog_mem_model (
   // Fetch port
   input  wire logic [15:0] pm_addr,
   output logic      [7:0]  pm_data
);
   logic [7:0] mem [0:255];

   // Only page zero is stored; higher pages answer with an opcode the core retires as a no-op
   assign pm_data = (pm_addr[15:8] == 8'h00) ? mem[pm_addr[7:0]] : 8'h00;
endmodule

/* test/test_cpu_branch_sub_xor_exchange_ops.sv */
// Self-checking bench for the branch, subtract, trade and xor core
`timescale 1ns/10ps
module test_cpu_branch_sub_xor_exchange_ops
   import branch_sub_xor_pkg::*;
;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic [1:0]  bank_sel = 2'h0;
   logic [7:0]  port_pins = 8'h00;
   logic [15:0] pm_addr;
   logic [7:0]  pm_data;
   logic [7:0]  acc;
   logic [7:0]  port_latch;
   logic        carry_flag;
   logic        half_borrow_flag;
   logic        signed_wrap_flag;
   logic        instr_done;
   logic [1:0]  instr_cycles;
   int          errors = 0;
   int          n_tests = 0;

   // Free-running 250 MHz core clock
   always #2 clock = ~clock;

   branch_sub_xor_core uut (
      .clock(clock), .srst(srst), .pm_addr(pm_addr), .pm_data(pm_data),
      .bank_sel(bank_sel), .port_pins(port_pins), .acc(acc), .carry_flag(carry_flag),
      .half_borrow_flag(half_borrow_flag), .signed_wrap_flag(signed_wrap_flag),
      .port_latch(port_latch), .instr_done(instr_done), .instr_cycles(instr_cycles)
   );

   prog_mem_model pm (.pm_addr(pm_addr), .pm_data(pm_data));

   // ****************************************
   // Shared tasks
   // ****************************************
   // Value compare, counted
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   // Accumulator plus the three flags {carry, half-borrow, signed-wrap}
   task automatic ck(input logic [7:0] a, input logic [2:0] f);
      chk({8'h00, acc}, {8'h00, a});
      chk({13'h0000, carry_flag, half_borrow_flag, signed_wrap_flag}, {13'h0000, f});
   endtask

   // Load n program bytes, first byte in the top of v, then reset for 3 clocks
   task automatic boot(input logic [255:0] v, input int n);
      srst = 1'b1;
      for (int i = 0; i < 256; i++)
         pm.mem[i] = 8'h00;
      for (int i = 0; i < n; i++)
         pm.mem[i] = v[(n - 1 - i) * 8 +: 8];
      repeat (3) @(posedge clock);
      #1 srst = 1'b0;
   endtask

   // Retire k instructions; a hung sequencer must not stall the run
   task automatic step(input int k);
      int w;
      for (int j = 0; j < k; j++) begin
         w = 0;
         do begin
            @(posedge clock);
            #1 w++;
         end while (instr_done !== 1'b1 && w < 50);
         if (w >= 50) begin
            errors++;
            $display("[ERR] %0t got %0h exp %0h", $time, instr_done, 1'b1);
         end
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // Branch at both ends of the reach, then a jump onto itself
   task automatic branch_test;
      boot(16'h807F, 2);
      pm.mem[8'h81] = OP_BRANCH;
      pm.mem[8'h82] = 8'h80;
      pm.mem[8'h03] = OP_BRANCH;
      pm.mem[8'h04] = 8'hFE;
      step(1);
      chk(pm_addr, 16'h0081);
      chk({14'h0000, instr_cycles}, 16'h0002);
      step(1);
      chk(pm_addr, 16'h0003);
      step(1);
      chk(pm_addr, 16'h0003);
   endtask

   // Subtract in all four source forms; RAM is seeded through trades
   task automatic sub_test;
      port_pins = 8'h00;
      boot(176'h9401_64AB_C502_C590_64C9_9A95_0264_22C5_00C5_9064_1096, 22);
      step(1);
      ck(8'hFF, 3'h6);
      chk({14'h0000, instr_cycles}, 16'h0001);
      step(4);
      ck(8'hC9, 3'h6);
      step(1);
      ck(8'h74, 3'h1);
      step(1);
      ck(8'h20, 3'h0);
      step(4);
      step(1);
      ck(8'hBC, 3'h6);
   endtask

   // Nibble rotate, byte trades and low-nibble trade keep the flags
   task automatic trade_test;
      port_pins = 8'h00;
      boot(216'h9401_643A_C464_29C5_20C5_9064_20C5_00C5_9064_3FC6_C520_6409_D6C5_20, 27);
      step(1);
      step(2);
      ck(8'h5C, 3'h6);
      chk(pm_addr, 16'h0005);
      step(8);
      ck(8'h75, 3'h6);
      step(1);
      ck(8'h3F, 3'h6);
      step(2);
      ck(8'h35, 3'h6);
      step(1);
      ck(8'h76, 3'h6);
   endtask

   // Xor into port latch, into accumulator from every source
   task automatic xor_test;
      port_pins = 8'h5A;
      boot(248'h9401_6390_3164_F062_9065_9064_FFC8_C590_6499_68C5_40C5_9064_1AC9_C590_64AA_67, 31);
      step(2);
      chk({8'h00, port_latch}, 16'h00CE);
      chk({14'h0000, instr_cycles}, 16'h0002);
      chk(pm_addr, 16'h0005);
      step(2);
      chk({8'h00, port_latch}, 16'h00C1);
      ck(8'h0F, 3'h6);
      step(1);
      ck(8'h55, 3'h6);
      step(5);
      ck(8'h69, 3'h6);
      chk({14'h0000, instr_cycles}, 16'h0001);
      step(7);
      ck(8'h99, 3'h6);
   endtask

   // ****************************************
   // Run control
   // ****************************************
   task automatic finish_test;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Whole run needs a few hundred clocks; this margin only catches a hang
   initial begin
      #40000;
      errors++;
      finish_test();
   end

   initial begin
      branch_test();
      sub_test();
      trade_test();
      xor_test();
      finish_test();
   end
endmodule
